// file: logic/amb_alert_gate.sv
// combines latched status bytes with mask bytes into one hit bit per byte
// assumes status bytes are latched by their owners on clk_i
`timescale 1ns/10ps
module amb_alert_gate
   import amb_pkg::*;
#(
   parameter int N = AMB_NREG
) (
   // status and masks
   input wire logic [8*N-1:0] status_i,
   input wire logic [8*N-1:0] mask_i,
   // per-byte result
   output logic [N-1:0] hit_o
);
   // elaboration check: at least one byte to gate
   if (N < 1) begin : gen_bad_n
      $error("amb_alert_gate needs at least one byte");
   end

   // bit set and mask 0 lets the condition through
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_byte
         assign hit_o[g] = |(status_i[8*g+:8] & ~mask_i[8*g+:8]);
      end
   endgenerate
endmodule

// file: logic/amb_bank.sv
// alert mask bank: decodes shared mask command, holds four masks, gates alert
// assumes an upstream bus slave parses transactions into the strobes below
`timescale 1ns/10ps
module amb_bank
   import amb_pkg::*;
#(
   parameter int N = AMB_NREG
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // nonvolatile image presented at reset release
   input wire logic nvm_valid_i,
   input wire logic [7:0] nvm_input_i,
   input wire logic [7:0] nvm_temp_i,
   input wire logic [7:0] nvm_comm_i,
   // parsed word write: command, selector, data byte
   input wire logic wr_word_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] sel_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [7:0] page_i,
   // parsed process call read
   input wire logic rd_call_i,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic rd_nack_o,
   // latched status conditions
   input wire logic [7:0] input_status_i,
   input wire logic [7:0] temperature_condition_status_i,
   input wire logic [7:0] comm_logic_condition_status_i,
   input wire logic [7:0] misc_status_i,
   input wire logic maker_alert_i,
   // mask view and alert
   output logic [7:0] input_alert_mask_o,
   output logic [7:0] temperature_alert_mask_o,
   output logic [7:0] comm_logic_alert_mask_o,
   output logic [7:0] misc_alert_mask_o,
   output logic alert_o,
   output logic ready_o
);
   // ==========================================================
   // elaboration check
   if (N != 4) begin : gen_bad_n
      $error("amb_bank serves exactly four mask bytes");
   end

   // ==========================================================
   // load sequencer
   amb_state_t state;
   amb_state_t next_state;
   wire loading = (state == AMB_LOAD) && nvm_valid_i;

   // wait for storage image, then run
   always_comb begin
      next_state = state;
      case (state)
         AMB_IDLE: next_state = AMB_LOAD;
         AMB_LOAD: if (nvm_valid_i) next_state = AMB_RUN;
         AMB_RUN: next_state = AMB_RUN;
         default: next_state = AMB_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= AMB_IDLE;
      end else begin
         state <= next_state;
      end
   end
   assign ready_o = (state == AMB_RUN);

   // ==========================================================
   // selector decode
   wire is_cmd = (cmd_i == AMB_MASK_CMD);
   wire paged_ok = (page_i == AMB_PAGE_ALL);
   wire hit_input = is_cmd && sel_i == AMB_SEL_INPUT;
   wire hit_temp = is_cmd && sel_i == AMB_SEL_TEMP;
   wire hit_comm = is_cmd && sel_i == AMB_SEL_COMM;
   wire hit_misc = is_cmd && sel_i == AMB_SEL_MISC;
   wire hit_maker = is_cmd && sel_i == AMB_SEL_MAKER;
   wire wr_ok = wr_word_i && ready_o;
   wire wr_input = wr_ok && hit_input && paged_ok;
   wire wr_temp = wr_ok && hit_temp && paged_ok;
   wire wr_comm = wr_ok && hit_comm && paged_ok;

   // ==========================================================
   // mask registers
   amb_mask_reg #(.WMASK(AMB_WMASK_INPUT), .FIXED(AMB_FIXED_INPUT)) u_input (
      .clk_i(clk_i), .rstn_i(rstn_i), .load_i(loading), .load_data_i(nvm_input_i),
      .wr_i(wr_input), .wr_data_i(wr_data_i), .value_o(input_alert_mask_o));
   amb_mask_reg #(.WMASK(AMB_WMASK_TEMP), .FIXED(AMB_FIXED_TEMP)) u_temp (
      .clk_i(clk_i), .rstn_i(rstn_i), .load_i(loading), .load_data_i(nvm_temp_i),
      .wr_i(wr_temp), .wr_data_i(wr_data_i), .value_o(temperature_alert_mask_o));
   amb_mask_reg #(.WMASK(AMB_WMASK_COMM), .FIXED(AMB_FIXED_COMM)) u_comm (
      .clk_i(clk_i), .rstn_i(rstn_i), .load_i(loading), .load_data_i(nvm_comm_i),
      .wr_i(wr_comm), .wr_data_i(wr_data_i), .value_o(comm_logic_alert_mask_o));
   amb_mask_reg #(.WMASK(AMB_WMASK_MISC), .FIXED(AMB_FIXED_MISC)) u_misc (
      .clk_i(clk_i), .rstn_i(rstn_i), .load_i(1'b0), .load_data_i(8'h00),
      .wr_i(wr_ok && hit_misc), .wr_data_i(wr_data_i), .value_o(misc_alert_mask_o));

   // ==========================================================
   // alert combine
   logic [N-1:0] hits;
   amb_alert_gate #(.N(N)) u_gate (
      .status_i({misc_status_i, comm_logic_condition_status_i,
                 temperature_condition_status_i, input_status_i}),
      .mask_i({misc_alert_mask_o, comm_logic_alert_mask_o,
               temperature_alert_mask_o, input_alert_mask_o}),
      .hit_o(hits));
   wire next_alert = ready_o && ((|hits) || maker_alert_i);

   // ==========================================================
   // read path: data registered one cycle after the call
   wire rd_hit = hit_input || hit_temp || hit_comm || hit_misc;
   wire rd_paged = (hit_misc || paged_ok);
   wire [7:0] rd_mux = hit_input ? input_alert_mask_o :
                       hit_temp ? temperature_alert_mask_o :
                       hit_comm ? comm_logic_alert_mask_o :
                       hit_misc ? misc_alert_mask_o : 8'h00; // maker reads are refused
   wire rd_good = rd_call_i && rd_hit && rd_paged;

   // read answer and alert registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_valid_o <= 1'b0;
         rd_nack_o <= 1'b0;
         rd_data_o <= 8'h00;
         alert_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_good;
         rd_nack_o <= rd_call_i && !rd_good;
         rd_data_o <= rd_good ? rd_mux : 8'h00;
         alert_o <= next_alert;
      end
   end

   // ==========================================================
   // checks
   // read answers: data, refusals and quiet cycles
   AST_READ_DATA: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (rd_call_i && is_cmd && sel_i == AMB_SEL_TEMP && paged_ok)
      |=> rd_valid_o && rd_data_o == $past(temperature_alert_mask_o))
      else $error("temperature mask read back wrong");
   AST_MAKER_NACK: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (rd_call_i && hit_maker) |=> rd_nack_o && !rd_valid_o)
      else $error("maker mask read not refused");
   AST_PAGE_NACK: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (rd_call_i && (hit_input || hit_temp || hit_comm) && !paged_ok) |=> rd_nack_o)
      else $error("read with wrong page not refused");
   AST_MISC_PAGE_FREE: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (rd_call_i && hit_misc) |=> rd_valid_o && rd_data_o == AMB_FIXED_MISC)
      else $error("misc mask read not answered");
   AST_ONE_ANSWER: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !(rd_valid_o && rd_nack_o))
      else $error("read both answered and refused");
   AST_QUIET_BUS: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !rd_call_i |=> !rd_valid_o && !rd_nack_o)
      else $error("read answer without a call");

   // fixed bit layouts
   AST_INPUT_LAYOUT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (input_alert_mask_o & 8'hF7) == 8'h00)
      else $error("input mask fixed bits nonzero");
   AST_TEMP_LAYOUT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      temperature_alert_mask_o[5:0] == 6'h00)
      else $error("temperature mask low bits nonzero");
   AST_COMM_LAYOUT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      comm_logic_alert_mask_o[3:2] == 2'h0 && !comm_logic_alert_mask_o[0])
      else $error("comm mask fixed bits nonzero");
   AST_MISC_FIXED: assert property (@(posedge clk_i) disable iff (!rstn_i)
      misc_alert_mask_o == 8'h01)
      else $error("misc mask not 01");

   // alert combine behaviour
   AST_FIRST_NO_ALERT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ready_o && misc_status_i == 8'h01 && !maker_alert_i && input_status_i == 8'h00
       && temperature_condition_status_i == 8'h00
       && comm_logic_condition_status_i == 8'h00) |=> !alert_o)
      else $error("first-alerter raised alert");
   AST_UNMASKED_ALERT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ready_o && (|(temperature_condition_status_i & ~temperature_alert_mask_o)))
      |=> alert_o)
      else $error("unmasked temperature did not alert");
   AST_INPUT_ALERT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ready_o && (|(input_status_i & ~input_alert_mask_o))) |=> alert_o)
      else $error("unmasked input condition did not alert");
   AST_COMM_ALERT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ready_o && (|(comm_logic_condition_status_i & ~comm_logic_alert_mask_o)))
      |=> alert_o)
      else $error("unmasked comm condition did not alert");
   AST_ALERT_GATED: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !ready_o |=> !alert_o)
      else $error("alert raised before masks loaded");

   // write guards and load
   AST_PAGE_GUARD: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (wr_word_i && hit_input && !paged_ok && !loading)
      |=> $stable(input_alert_mask_o))
      else $error("write with wrong page changed mask");
   AST_CMD_GUARD: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (wr_word_i && !is_cmd && !loading)
      |=> $stable(input_alert_mask_o) && $stable(temperature_alert_mask_o)
          && $stable(comm_logic_alert_mask_o))
      else $error("write with other command changed a mask");
   AST_LOAD_APPLY: assert property (@(posedge clk_i) disable iff (!rstn_i)
      loading |=> input_alert_mask_o == ($past(nvm_input_i) & AMB_WMASK_INPUT))
      else $error("storage image not loaded");
   AST_READY_HOLDS: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ready_o |=> ready_o)
      else $error("ready dropped without reset");

   // main scenarios reached
   COV_WRITE_COMM: cover property (@(posedge clk_i) disable iff (!rstn_i) wr_comm);
   COV_READ_MISC: cover property (@(posedge clk_i) disable iff (!rstn_i)
      rd_call_i && hit_misc);
   COV_ALERT: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(alert_o));
   COV_LOAD_WAIT: cover property (@(posedge clk_i) disable iff (!rstn_i)
      state == AMB_LOAD && !nvm_valid_i);
   COV_PAGE_REFUSE: cover property (@(posedge clk_i) disable iff (!rstn_i)
      rd_call_i && hit_temp && !paged_ok);
endmodule

// file: logic/amb_mask_reg.sv
// one alert mask byte with writable-bit layout and fixed bits
// assumes write strobe and load strobe come from the bank on clk_i
`timescale 1ns/10ps
module amb_mask_reg
   import amb_pkg::*;
#(
   parameter logic [7:0] WMASK = 8'h00,
   parameter logic [7:0] FIXED = 8'h00
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // load and write
   input wire logic load_i,
   input wire logic [7:0] load_data_i,
   input wire logic wr_i,
   input wire logic [7:0] wr_data_i,
   // value
   output logic [7:0] value_o
);
   logic [7:0] held;
   logic [7:0] next_held;

   // writable bits take data, fixed bits never move
   assign next_held = load_i ? (load_data_i & WMASK) :
                      wr_i ? (wr_data_i & WMASK) : held;
   assign value_o = (held & WMASK) | (FIXED & ~WMASK);

   // storage
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         held <= 8'h00;
      end else begin
         held <= next_held;
      end
   end

   AST_FIXED_BITS: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (value_o & ~WMASK) == (FIXED & ~WMASK))
      else $error("fixed mask bit moved");
   AST_WRITE_TAKES: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (wr_i && !load_i) |=> value_o == (($past(wr_data_i) & WMASK) | (FIXED & ~WMASK)))
      else $error("mask write not applied next cycle");
endmodule

// file: logic/amb_pkg.sv
// alert mask bank package: selectors, field layouts, reset values
// assumes the command decoder presents the shared mask command already parsed
//
// Contract
// - masks written by word write on 1Bh
// - masks read back through process call
// - selector 7Ch picks input mask
// - selector 7Dh picks temperature mask
// - selector 7Eh picks comm/logic mask
// - selector 7Fh picks miscellaneous mask
// - selector 80h picks maker mask (no maker mask held here: reads refused, writes ignored)
// - mask bit 0 passes, 1 blocks alert
// - each mask is one bitwise byte
// - input mask only bit 3 writable
// - temperature mask bits 7,6 writable only
// - comm mask bits 7..4 and 1 writable
// - miscellaneous mask bits 7..1 read zero
// - first-alerter bit fixed one, never alerts
// - masks load from storage, apply immediately
// - input/temp/comm need page FFh
package amb_pkg;
   // ==========================================================
   // command and selector codes
   localparam logic [7:0] AMB_MASK_CMD = 8'h1B;
   localparam logic [7:0] AMB_SEL_INPUT = 8'h7C;
   localparam logic [7:0] AMB_SEL_TEMP = 8'h7D;
   localparam logic [7:0] AMB_SEL_COMM = 8'h7E;
   localparam logic [7:0] AMB_SEL_MISC = 8'h7F;
   localparam logic [7:0] AMB_SEL_MAKER = 8'h80;
   localparam logic [7:0] AMB_PAGE_ALL = 8'hFF;
   // ==========================================================
   // writable-bit layouts
   localparam logic [7:0] AMB_WMASK_INPUT = 8'h08;
   localparam logic [7:0] AMB_WMASK_TEMP = 8'hC0;
   localparam logic [7:0] AMB_WMASK_COMM = 8'hF2;
   localparam logic [7:0] AMB_WMASK_MISC = 8'h00;
   // ==========================================================
   // fixed values of read-only bits
   localparam logic [7:0] AMB_FIXED_INPUT = 8'h00;
   localparam logic [7:0] AMB_FIXED_TEMP = 8'h00;
   localparam logic [7:0] AMB_FIXED_COMM = 8'h00;
   localparam logic [7:0] AMB_FIXED_MISC = 8'h01;
   // ==========================================================
   // bank size and load states
   localparam int AMB_NREG = 4;
   typedef enum {AMB_IDLE, AMB_LOAD, AMB_RUN} amb_state_t;
endpackage

// file: test/amb_host_model.sv
// management bus host model issuing parsed writes and reads
// assumes the bank samples requests on the rising edge of clk_i
`timescale 1ns/10ps
module amb_host_model
   import amb_pkg::*;
(
   // clock
   input wire logic clk_i,
   // requests
   output logic wr_word_o,
   output logic rd_call_o,
   output logic [7:0] cmd_o,
   output logic [7:0] sel_o,
   output logic [7:0] data_o,
   output logic [7:0] page_o,
   // answer
   input wire logic rd_valid_i,
   input wire logic rd_nack_i,
   input wire logic [7:0] rd_data_i
);
   // ==========================================
   // idle bus
   initial begin
      wr_word_o = 1'b0;
      rd_call_o = 1'b0;
      {cmd_o, sel_o, data_o, page_o} = 32'h0;
   end
   // word write, command, selector and data scrambled once released, page kept
   task automatic wr(input logic [7:0] c, s, d, p);
      @(negedge clk_i);
      {cmd_o, sel_o, data_o, page_o} = {c, s, d, p};
      wr_word_o = 1'b1;
      @(negedge clk_i);
      wr_word_o = 1'b0;
      {cmd_o, sel_o, data_o} = ~{c, s, d};
   endtask
   // process call read, one-cycle answer taken at the next falling edge
   task automatic rd(input logic [7:0] c, s, p, output logic v, nk, output logic [7:0] d);
      @(negedge clk_i);
      {cmd_o, sel_o, page_o} = {c, s, p};
      rd_call_o = 1'b1;
      @(negedge clk_i);
      {v, nk, d} = {rd_valid_i, rd_nack_i, rd_data_i};
      rd_call_o = 1'b0;
      {cmd_o, sel_o} = ~{c, s};
   endtask
endmodule

// file: test/tb_alert_source_mask_bank.sv
// testbench for the alert mask bank
// assumes the host model drives the parsed request lines
`timescale 1ns/10ps
module tb_alert_source_mask_bank;
   import amb_pkg::*;
   logic clk_i, rstn_i, nvm_valid_i, wr_word_i, rd_call_i, mk, rd_valid_o, rd_nack_o;
   logic alert_o, ready_o, v, nk;
   logic [7:0] cmd_i, sel_i, wr_data_i, page_i, s_in, s_tp, s_cm, s_ms, rd_data_o;
   logic [7:0] m_in, m_tp, m_cm, m_ms, d;
   logic [7:0] n_in, n_tp, n_cm;
   logic [7:0] sels [3] = '{AMB_SEL_INPUT, AMB_SEL_TEMP, AMB_SEL_COMM};
   logic [7:0] wms [3] = '{AMB_WMASK_INPUT, AMB_WMASK_TEMP, AMB_WMASK_COMM};
   int mismatches, checked;
   // ==========================================
   // clock, design and host
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   amb_bank i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .nvm_valid_i(nvm_valid_i),
      .nvm_input_i(n_in), .nvm_temp_i(n_tp), .nvm_comm_i(n_cm), .wr_word_i(wr_word_i),
      .cmd_i(cmd_i), .sel_i(sel_i), .wr_data_i(wr_data_i), .page_i(page_i),
      .rd_call_i(rd_call_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .rd_nack_o(rd_nack_o), .input_status_i(s_in), .temperature_condition_status_i(s_tp),
      .comm_logic_condition_status_i(s_cm), .misc_status_i(s_ms), .maker_alert_i(mk),
      .input_alert_mask_o(m_in), .temperature_alert_mask_o(m_tp),
      .comm_logic_alert_mask_o(m_cm), .misc_alert_mask_o(m_ms), .alert_o(alert_o),
      .ready_o(ready_o));
   amb_host_model i_host (.clk_i(clk_i), .wr_word_o(wr_word_i), .rd_call_o(rd_call_i),
      .cmd_o(cmd_i), .sel_o(sel_i), .data_o(wr_data_i), .page_o(page_i),
      .rd_valid_i(rd_valid_o), .rd_nack_i(rd_nack_o), .rd_data_i(rd_data_o));
   // ==========================================
   // compare helpers and verdict
   task automatic chk(input string nm, input logic [7:0] e, s);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rdc(input logic [7:0] s, p, e, input logic en);
      i_host.rd(AMB_MASK_CMD, s, p, v, nk, d);
      chk("rd_nack", {7'h0, en}, {7'h0, nk});
      chk("rd_valid", {7'h0, !en}, {7'h0, v});
      if (!en) chk("rd_data", e, d);
   endtask
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic al(input logic [7:0] a, b, c, e, input logic m, x);
      @(negedge clk_i);
      {s_in, s_tp, s_cm, s_ms, mk} = {a, b, c, e, m};
      repeat (2) @(negedge clk_i);
      chk("alert_o", {7'h0, x}, {7'h0, alert_o});
   endtask
   // ==========================================
   // scenarios
   task automatic t_load();
      int i;
      chk("misc_mask_rst", AMB_FIXED_MISC, m_ms);
      chk("input_mask_rst", 8'h00, m_in);
      rstn_i = 1'b1;
      for (i = 0; i < 100 && ready_o !== 1'b1; i++) @(negedge clk_i);
      chk("ready_o", 8'h01, {7'h0, ready_o});
      for (i = 0; i < 3; i++) rdc(sels[i], AMB_PAGE_ALL, wms[i], 1'b0);
      rdc(AMB_SEL_MISC, AMB_PAGE_ALL, 8'h01, 1'b0);
   endtask
   task automatic t_write();
      int i;
      for (i = 0; i < 3; i++) begin
         i_host.wr(AMB_MASK_CMD, sels[i], 8'h00, AMB_PAGE_ALL);
         rdc(sels[i], AMB_PAGE_ALL, 8'h00, 1'b0);
         i_host.wr(AMB_MASK_CMD, sels[i], ~wms[i], AMB_PAGE_ALL);
         rdc(sels[i], AMB_PAGE_ALL, 8'h00, 1'b0);
      end
      i_host.wr(AMB_MASK_CMD, AMB_SEL_TEMP, 8'hFF, AMB_PAGE_ALL);
      chk("temp_mask", AMB_WMASK_TEMP, m_tp);
      i_host.wr(AMB_MASK_CMD, AMB_SEL_COMM, 8'hFF, AMB_PAGE_ALL);
      chk("comm_mask", AMB_WMASK_COMM, m_cm);
      i_host.wr(AMB_MASK_CMD, AMB_SEL_MISC, 8'hFE, AMB_PAGE_ALL);
      chk("misc_mask", 8'h01, m_ms);
   endtask
   task automatic t_refuse();
      i_host.wr(AMB_MASK_CMD, AMB_SEL_INPUT, 8'hFF, 8'h00);
      i_host.wr(8'h1A, AMB_SEL_INPUT, 8'hFF, AMB_PAGE_ALL);
      rdc(AMB_SEL_INPUT, AMB_PAGE_ALL, 8'h00, 1'b0);
      rdc(AMB_SEL_TEMP, 8'h00, 8'h00, 1'b1);
      rdc(AMB_SEL_MAKER, AMB_PAGE_ALL, 8'h00, 1'b1);
      rdc(AMB_SEL_MISC, 8'h00, 8'h01, 1'b0);
   endtask
   task automatic t_alert();
      i_host.wr(AMB_MASK_CMD, AMB_SEL_TEMP, 8'h00, AMB_PAGE_ALL);
      i_host.wr(AMB_MASK_CMD, AMB_SEL_COMM, 8'h00, AMB_PAGE_ALL);
      al(8'h08, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
      i_host.wr(AMB_MASK_CMD, AMB_SEL_INPUT, 8'h08, AMB_PAGE_ALL);
      al(8'h08, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      al(8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0);
      al(8'h00, 8'h40, 8'h00, 8'h00, 1'b0, 1'b1);
      al(8'h00, 8'h00, 8'h02, 8'h00, 1'b0, 1'b1);
      al(8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
      al(8'hF7, 8'h3F, 8'h0D, 8'hFE, 1'b0, 1'b1);
      i_host.wr(AMB_MASK_CMD, AMB_SEL_TEMP, 8'hFF, AMB_PAGE_ALL);
      i_host.wr(AMB_MASK_CMD, AMB_SEL_COMM, 8'hFF, AMB_PAGE_ALL);
      al(8'h08, 8'hC0, 8'hF2, 8'h01, 1'b0, 1'b0);
   endtask
   // mid-run reset: image held back, then loaded with fixed bits set
   task automatic t_reload();
      @(negedge clk_i);
      rstn_i = 1'b0;
      nvm_valid_i = 1'b0;
      {n_in, n_tp, n_cm} = {8'hF7, 8'h7F, 8'h2D};
      repeat (2) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk("ready_wait", 8'h00, {7'h0, ready_o});
      chk("alert_gated", 8'h00, {7'h0, alert_o});
      nvm_valid_i = 1'b1;
      @(negedge clk_i);
      chk("ready_load", 8'h01, {7'h0, ready_o});
      rdc(AMB_SEL_INPUT, AMB_PAGE_ALL, 8'h00, 1'b0);
      rdc(AMB_SEL_TEMP, AMB_PAGE_ALL, 8'h40, 1'b0);
      rdc(AMB_SEL_COMM, AMB_PAGE_ALL, 8'h20, 1'b0);
      chk("alert_run", 8'h01, {7'h0, alert_o});
   endtask
   // ==========================================
   // main sequence
   initial begin
      {rstn_i, mk, s_in, s_tp, s_cm, s_ms} = '0;
      {nvm_valid_i, n_in, n_tp, n_cm} = {1'b1, 24'hFFFFFF};
      repeat (6) @(negedge clk_i);
      t_load();
      if (ready_o === 1'b1) begin
         t_write();
         t_refuse();
         t_alert();
         t_reload();
      end
      report_and_stop();
   end
endmodule
